// File: src/dcc_pkg.sv
// Constants, register map and mode codes for the dual comparator control.
//
// Notes on behaviour
// - Eight operating modes from 3-bit field.
// - Reset restores config, link, reference defaults.
// - Link bit 1 selects timer gate source.
// - Link bit 0 syncs second result.
// - Prescaler output clocks the sync latch when the prescaler is active, else the timer clock.
// - Latch on timer clock falling edge.
// - Config top bits read results, read-only.
// - Pin-out mode drives pins from synchronised, registered results.
// - Direction bits still enable both pins.
// - Two bits invert each result independently.
// - Output change sets flag bits 4, 3.
// - Flags cleared writing 0, set writing 1.
// - Request needs enable, peripheral, global enables.
// - Mismatch keeps setting; config access ends it.
// - Change during config access still sets its flag.
// - Reference has 16 levels in each of two ranges.
// - Reference bit 5 selects low range.
// - Bit 7 powers reference; off gives ground.
// - Active comparators wake device from Sleep.
// - Wake leaves control registers unchanged.
// - Result is one when positive input higher.
package dcc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0]  IDX_GLOBAL_IRQ   = 8'h0B;
   localparam logic [7:0]  IDX_PERIPH_FLAG  = 8'h0C;
   localparam logic [7:0]  IDX_CMP_CONFIG   = 8'h19;
   localparam logic [7:0]  IDX_TIMER_LINK   = 8'h1A;
   localparam logic [7:0]  IDX_PERIPH_EN    = 8'h8C;
   localparam logic [7:0]  IDX_REF_CONTROL  = 8'h99;
   localparam int          ADDR_W           = 12;
   localparam int          DATA_W           = 32;
   localparam int          REG_W            = 8;

   // Reset values
   localparam logic [7:0]  RST_GLOBAL_IRQ   = 8'h00;
   localparam logic [7:0]  RST_PERIPH_FLAG  = 8'h00;
   localparam logic [7:0]  RST_CMP_CONFIG   = 8'h00;
   localparam logic [7:0]  RST_TIMER_LINK   = 8'h02;
   localparam logic [7:0]  RST_PERIPH_EN    = 8'h00;
   localparam logic [7:0]  RST_REF_CONTROL  = 8'h00;

   // Writable bit masks (unimplemented bits read zero)
   localparam logic [7:0]  MASK_CMP_CONFIG  = 8'h3F;
   localparam logic [7:0]  MASK_TIMER_LINK  = 8'h03;
   localparam logic [7:0]  MASK_REF_CONTROL = 8'hAF;

   // Field positions
   localparam int          BIT_GLOBAL_EN    = 7;
   localparam int          BIT_PERIPH_EN    = 6;
   localparam int          BIT_SECOND_FLAG  = 4;
   localparam int          BIT_FIRST_FLAG   = 3;
   localparam int          BIT_SECOND_RES   = 7;
   localparam int          BIT_FIRST_RES    = 6;
   localparam int          BIT_SECOND_INV   = 5;
   localparam int          BIT_FIRST_INV    = 4;
   localparam int          BIT_INPUT_SWITCH = 3;
   localparam int          MODE_MSB         = 2;
   localparam int          BIT_GATE_SRC     = 1;
   localparam int          BIT_SYNC_EN      = 0;
   localparam int          BIT_REF_POWER    = 7;
   localparam int          BIT_REF_RANGE    = 5;
   localparam int          REF_CODE_MSB     = 3;

   // Reference level expressed in 96ths of supply
   localparam int          REF_LEVEL_W      = 7;
   localparam logic [6:0]  REF_LOW_STEP     = 7'h04;  // 96/24
   localparam logic [6:0]  REF_HIGH_STEP    = 7'h03;  // 96/32
   localparam logic [6:0]  REF_HIGH_BASE    = 7'h18;  // 96/4
   localparam logic [6:0]  REF_GROUND       = 7'h00;
   localparam logic [3:0]  REF_CODE_ZERO    = 4'h0;

   // Comparator operating modes
   typedef enum logic [2:0] {
      OPM_RESET        = 3'b000,
      OPM_ONE_SWITCHED = 3'b001,
      OPM_MUX_INPUTS   = 3'b010,
      OPM_COMMON_REF   = 3'b011,
      OPM_TWO_INDEP    = 3'b100,
      OPM_ONE_INDEP    = 3'b101,
      OPM_PIN_OUTPUT   = 3'b110,
      OPM_OFF          = 3'b111
   } dcc_mode_type;

endpackage : dcc_pkg

// File: src/dcc_sync2.sv
// Two-flop level synchroniser for asynchronous inputs.
`timescale 1ns/1ns
module dcc_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // First stage; read only by the second stage
   logic [WIDTH-1:0] meta_r;

   // Both stages clear to a constant under reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : dcc_sync2

// File: src/dcc_top.sv
// Dual comparator control: APB registers, polarity, pins, flags, reference.
`timescale 1ns/1ns
module dcc_top (
   // APB slave
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [dcc_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [dcc_pkg::DATA_W-1:0]   pwdata,
   output logic      [dcc_pkg::DATA_W-1:0]   prdata,
   output logic                              pready,
   output logic                              pslverr,
   // Raw analog comparison results, asynchronous
   input  wire logic                         first_raw,
   input  wire logic                         second_raw,
   // Timer side, asynchronous
   input  wire logic                         timer_gate_pin,
   input  wire logic                         timer_clk,
   input  wire logic                         timer_prescaled_clk,
   input  wire logic                         timer_prescale_active,
   output logic                              timer_gate_out,
   // Port side
   input  wire logic [1:0]                   pin_direction_bits,
   output logic                              first_pin_out,
   output logic                              first_pin_oe,
   output logic                              second_pin_out,
   output logic                              second_pin_oe,
   // Analog control
   output logic [2:0]                        operating_mode_sel,
   output logic                              input_switch,
   output logic                              comparators_powered,
   output logic                              reference_power_on,
   output logic                              reference_range_sel,
   output logic [3:0]                        reference_level_code,
   output logic [dcc_pkg::REF_LEVEL_W-1:0]   internal_reference_level,
   // Core side
   input  wire logic                         sleep_active,
   output logic                              change_irq,
   output logic                              wake_request
);

   // Functions

   // Byte address of a register index
   function automatic logic [dcc_pkg::ADDR_W-1:0] reg_addr(
      input logic [7:0] idx
   );
      reg_addr = {2'b00, idx, 2'b00};
   endfunction : reg_addr

   // Modes in which the comparators are powered and produce a result
   function automatic logic mode_active(input dcc_pkg::dcc_mode_type m);
      logic act;
      act = 1'b1;
      unique case (m)
         dcc_pkg::OPM_RESET:        act = 1'b0;
         dcc_pkg::OPM_ONE_SWITCHED: act = 1'b1;
         dcc_pkg::OPM_MUX_INPUTS:   act = 1'b1;
         dcc_pkg::OPM_COMMON_REF:   act = 1'b1;
         dcc_pkg::OPM_TWO_INDEP:    act = 1'b1;
         dcc_pkg::OPM_ONE_INDEP:    act = 1'b1;
         dcc_pkg::OPM_PIN_OUTPUT:   act = 1'b1;
         dcc_pkg::OPM_OFF:          act = 1'b0;
      endcase
      mode_active = act;
   endfunction : mode_active

   // Reference level in 96ths of supply from power, range and code
   function automatic logic [dcc_pkg::REF_LEVEL_W-1:0] ref_level(
      input logic       pwr,
      input logic       low_rng,
      input logic [3:0] code
   );
      logic [dcc_pkg::REF_LEVEL_W-1:0] c;
      c = {3'b000, code};
      if (!pwr)
         ref_level = dcc_pkg::REF_GROUND;
      else if (low_rng)
         ref_level = 7'(c * dcc_pkg::REF_LOW_STEP);
      else
         ref_level = 7'(dcc_pkg::REF_HIGH_BASE + c * dcc_pkg::REF_HIGH_STEP);
   endfunction : ref_level

   // Registers
   logic [7:0]              global_interrupt_control_r; // Global enables
   logic [7:0]              peripheral_flag_reg_r;      // Flags
   logic [7:0]              comparator_config_r;        // Writable bits 5:0
   logic [7:0]              comparator_timer_link_r;    // Gate and sync
   logic [7:0]              peripheral_enable_reg_r;    // Source enables
   logic [7:0]              reference_control_r;        // Reference setup
   logic [7:0]              peripheral_flag_reg_nxt;    // Flag next value
   logic [1:0]              result_r;                   // Polarised results
   logic [1:0]              latched_r;                  // Last seen results
   logic                    second_synced_r;            // Timer-synced result
   logic                    tclk_prev_r;                // Timer clock history
   logic [dcc_pkg::DATA_W-1:0] prdata_r;                // Read data hold
   logic                    first_pin_out_r;
   logic                    second_pin_out_r;
   logic                    first_pin_oe_r;
   logic                    second_pin_oe_r;
   logic                    timer_gate_out_r;

   // Input synchronisers
   logic [5:0]              async_bundle;
   logic [5:0]              sync_bundle;
   logic                    first_raw_s;
   logic                    second_raw_s;
   logic                    gate_pin_s;
   logic                    tclk_s;
   logic                    tclk_pre_s;
   logic                    prescale_s;

   assign async_bundle = {timer_prescale_active, timer_prescaled_clk,
                          timer_clk, timer_gate_pin, second_raw, first_raw};

   dcc_sync2 #(
      .WIDTH    (6)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (async_bundle),
      .sync_out (sync_bundle)
   );

   assign first_raw_s  = sync_bundle[0];
   assign second_raw_s = sync_bundle[1];
   assign gate_pin_s   = sync_bundle[2];
   assign tclk_s       = sync_bundle[3];
   assign tclk_pre_s   = sync_bundle[4];
   assign prescale_s   = sync_bundle[5];

   // APB decode
   logic                    setup_ph;
   logic                    access_ph;
   logic                    wr_en;
   logic                    sel_gic;
   logic                    sel_pfr;
   logic                    sel_cfg;
   logic                    sel_lnk;
   logic                    sel_pie;
   logic                    sel_ref;
   logic                    sel_any;
   logic                    cfg_touch;
   logic [7:0]              wbyte;
   logic [7:0]              rd_byte;

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   assign wbyte     = pwdata[dcc_pkg::REG_W-1:0];
   assign sel_gic   = (paddr == reg_addr(dcc_pkg::IDX_GLOBAL_IRQ));
   assign sel_pfr   = (paddr == reg_addr(dcc_pkg::IDX_PERIPH_FLAG));
   assign sel_cfg   = (paddr == reg_addr(dcc_pkg::IDX_CMP_CONFIG));
   assign sel_lnk   = (paddr == reg_addr(dcc_pkg::IDX_TIMER_LINK));
   assign sel_pie   = (paddr == reg_addr(dcc_pkg::IDX_PERIPH_EN));
   assign sel_ref   = (paddr == reg_addr(dcc_pkg::IDX_REF_CONTROL));
   assign sel_any   = sel_gic | sel_pfr | sel_cfg | sel_lnk | sel_pie
                    | sel_ref;
   assign wr_en     = access_ph & pwrite & sel_any;
   // any completed config access ends a mismatch
   assign cfg_touch = access_ph & sel_cfg;

   // Zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access_ph & ~sel_any;
   assign prdata  = prdata_r;

   // Field views
   dcc_pkg::dcc_mode_type   mode;
   logic                    active;
   logic                    pin_mode;
   logic [1:0]              invert;
   logic [1:0]              result_nxt;
   logic [1:0]              mismatch;
   logic [1:0]              irq_src;
   logic                    gate_src_pin;
   logic                    sync_en;
   logic                    sync_clk;
   logic                    sync_fall;
   logic                    second_gate;

   assign mode         = dcc_pkg::dcc_mode_type'(
                            comparator_config_r[dcc_pkg::MODE_MSB:0]);
   assign active       = mode_active(mode);
   assign pin_mode     = (mode == dcc_pkg::OPM_PIN_OUTPUT);
   assign invert       = {comparator_config_r[dcc_pkg::BIT_SECOND_INV],
                          comparator_config_r[dcc_pkg::BIT_FIRST_INV]};
   // raw high means positive input exceeds negative
   assign result_nxt   = active ? ({second_raw_s, first_raw_s} ^ invert)
                                : 2'b00;
   // change against the last latched value
   assign mismatch     = result_r ^ latched_r;

   assign gate_src_pin = comparator_timer_link_r[dcc_pkg::BIT_GATE_SRC];
   assign sync_en      = comparator_timer_link_r[dcc_pkg::BIT_SYNC_EN];
   // prescaler output clocks the latch when in use
   assign sync_clk     = prescale_s ? tclk_pre_s : tclk_s;
   // capture on the falling edge, counter uses rising
   assign sync_fall    = tclk_prev_r & ~sync_clk;
   assign second_gate  = sync_en ? second_synced_r : result_r[1];

   // all three enables needed for a request
   assign irq_src = {peripheral_flag_reg_r[dcc_pkg::BIT_SECOND_FLAG]
                     & peripheral_enable_reg_r[dcc_pkg::BIT_SECOND_FLAG],
                     peripheral_flag_reg_r[dcc_pkg::BIT_FIRST_FLAG]
                     & peripheral_enable_reg_r[dcc_pkg::BIT_FIRST_FLAG]};
   assign change_irq = (|irq_src)
                     & global_interrupt_control_r[dcc_pkg::BIT_PERIPH_EN]
                     & global_interrupt_control_r[dcc_pkg::BIT_GLOBAL_EN];
   // wake does not need the global enable
   assign wake_request = sleep_active & active & (|irq_src)
                       & global_interrupt_control_r[dcc_pkg::BIT_PERIPH_EN];

   // Read multiplexer; results appear in the top two config bits
   // result bits come from hardware, not storage
   assign rd_byte =
        sel_gic ? global_interrupt_control_r
      : sel_pfr ? peripheral_flag_reg_r
      : sel_cfg ? {result_r,
                   comparator_config_r[dcc_pkg::BIT_SECOND_INV:0]}
      : sel_lnk ? comparator_timer_link_r
      : sel_pie ? peripheral_enable_reg_r
      : sel_ref ? reference_control_r
      : 8'h00;

   // software write stores 0 or 1 in each flag
   // mismatch keeps re-setting, set wins over the clear
   always_comb begin
      peripheral_flag_reg_nxt = peripheral_flag_reg_r;
      if (wr_en && sel_pfr)
         peripheral_flag_reg_nxt = wbyte;
      if (mismatch[1])
         peripheral_flag_reg_nxt[dcc_pkg::BIT_SECOND_FLAG] = 1'b1;
      if (mismatch[0])
         peripheral_flag_reg_nxt[dcc_pkg::BIT_FIRST_FLAG] = 1'b1;
   end

   // Software registers
   // reset defaults; nothing else touches these
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_interrupt_control_r <= dcc_pkg::RST_GLOBAL_IRQ;
         comparator_config_r        <= dcc_pkg::RST_CMP_CONFIG;
         comparator_timer_link_r    <= dcc_pkg::RST_TIMER_LINK;
         peripheral_enable_reg_r    <= dcc_pkg::RST_PERIPH_EN;
         reference_control_r        <= dcc_pkg::RST_REF_CONTROL;
      end else if (wr_en) begin
         if (sel_gic)
            global_interrupt_control_r <= wbyte;
         // result bits are masked out of the write
         if (sel_cfg)
            comparator_config_r <= wbyte & dcc_pkg::MASK_CMP_CONFIG;
         // gate select and sync enable are stored here
         if (sel_lnk)
            comparator_timer_link_r <= wbyte & dcc_pkg::MASK_TIMER_LINK;
         if (sel_pie)
            peripheral_enable_reg_r <= wbyte;
         if (sel_ref)
            reference_control_r <= wbyte & dcc_pkg::MASK_REF_CONTROL;
      end
   end

   // Flag register; hardware sets every cycle a mismatch stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         peripheral_flag_reg_r <= dcc_pkg::RST_PERIPH_FLAG;
      else
         peripheral_flag_reg_r <= peripheral_flag_reg_nxt;
   end

   // Read data is captured in the setup phase so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata_r <= '0;
      else if (setup_ph)
         prdata_r <= {{(dcc_pkg::DATA_W-dcc_pkg::REG_W){1'b0}}, rd_byte};
   end

   // Comparator results and change latch
   // Latch takes the current result on any config access; a change in
   // that same cycle leaves a standing mismatch that keeps setting its flag, so none is lost
   // a change at the read edge leaves the latch on the old value, so it still mismatches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_r  <= 2'b00;
         latched_r <= 2'b00;
      end else begin
         result_r <= result_nxt;
         if (cfg_touch)
            latched_r <= result_r;
      end
   end

   // Timer-clock falling edge latch of the second result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tclk_prev_r     <= 1'b0;
         second_synced_r <= 1'b0;
      end else begin
         tclk_prev_r <= sync_clk;
         if (sync_fall)
            second_synced_r <= result_r[1];
      end
   end

   // Pins and timer gate
   // Direction bit set means input, so the enable is its complement
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_pin_out_r  <= 1'b0;
         second_pin_out_r <= 1'b0;
         first_pin_oe_r   <= 1'b0;
         second_pin_oe_r  <= 1'b0;
         timer_gate_out_r <= 1'b0;
      end else begin
         first_pin_out_r  <= pin_mode & result_nxt[0];
         second_pin_out_r <= pin_mode & result_nxt[1];
         first_pin_oe_r   <= pin_mode & ~pin_direction_bits[0];
         second_pin_oe_r  <= pin_mode & ~pin_direction_bits[1];
         timer_gate_out_r <= gate_src_pin ? gate_pin_s : second_gate;
      end
   end

   assign first_pin_out  = first_pin_out_r;
   assign second_pin_out = second_pin_out_r;
   assign first_pin_oe   = first_pin_oe_r;
   assign second_pin_oe  = second_pin_oe_r;
   assign timer_gate_out = timer_gate_out_r;

   // Analog control outputs and reference
   assign operating_mode_sel   = comparator_config_r[dcc_pkg::MODE_MSB:0];
   assign input_switch         =
      comparator_config_r[dcc_pkg::BIT_INPUT_SWITCH];
   // comparators stay powered in Sleep when enabled
   assign comparators_powered  = active;
   assign reference_power_on   = reference_control_r[dcc_pkg::BIT_REF_POWER];
   // range bit, one selects the low range
   assign reference_range_sel  = reference_control_r[dcc_pkg::BIT_REF_RANGE];
   assign reference_level_code =
      reference_control_r[dcc_pkg::REF_CODE_MSB:0];
   assign internal_reference_level =
      ref_level(reference_power_on, reference_range_sel,
                reference_level_code);

endmodule : dcc_top

// File: tb/dcc_checker.sv
// Port checker for the comparator control block.
`timescale 1ns/1ns
module dcc_checker (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic [2:0] operating_mode_sel,
   input wire logic       comparators_powered,
   input wire logic       reference_power_on,
   input wire logic       reference_range_sel,
   input wire logic [3:0] reference_level_code,
   input wire logic [6:0] internal_reference_level,
   input wire logic [1:0] pin_direction_bits,
   input wire logic       first_pin_out,
   input wire logic       second_pin_out,
   input wire logic       first_pin_oe,
   input wire logic       sleep_active,
   input wire logic       wake_request
);
   // One domain, so clock and reset are shared by all properties
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_mode_power: assert property (
      comparators_powered == (operating_mode_sel inside {[3'h1:3'h6]}))
      else $error("power flag wrong");
   a_ref_off: assert property (
      !reference_power_on |-> internal_reference_level == 7'h00)
      else $error("reference not ground");
   a_ref_low: assert property (
      reference_power_on && reference_range_sel |->
      internal_reference_level == reference_level_code * 7'h04)
      else $error("low range level wrong");
   a_ref_high: assert property (
      reference_power_on && !reference_range_sel |->
      internal_reference_level == 7'h18 + reference_level_code * 7'h03)
      else $error("high range level wrong");
   a_pin_mux: assert property (
      first_pin_out || second_pin_out |-> $past(operating_mode_sel) == 3'h6)
      else $error("pin driven outside pin mode");
   a_pin_enable: assert property (
      first_pin_oe |-> $past(operating_mode_sel) == 3'h6 &&
      !$past(pin_direction_bits[0])) else $error("pin enable wrong");
   a_wake_cause: assert property (
      wake_request |-> sleep_active && comparators_powered)
      else $error("wake without cause");
   a_reset_mode: assert property (
      $rose(presetn) |-> operating_mode_sel == 3'h0 && !reference_power_on)
      else $error("reset state wrong");
endmodule : dcc_checker

// File: tb/dcc_far_model.sv
// Far side: two analog comparators and the timer clock source.
`timescale 1ns/1ns
module dcc_far_model (
   input  wire logic [7:0] first_pos,
   input  wire logic [7:0] second_pos,
   input  wire logic       timer_gate_out,
   output logic            first_raw,
   output logic            second_raw,
   output logic            timer_clk = 1'b0,
   output logic            timer_prescaled_clk = 1'b0
);
   localparam logic [7:0] NEG_LEVEL = 8'h80; // Shared negative input
   logic [7:0]            count_r = 8'h00;   // Gated timer count
   assign first_raw  = first_pos > NEG_LEVEL;
   assign second_raw = second_pos > NEG_LEVEL;
   // Free running, unrelated in phase to pclk
   always #70 timer_clk = ~timer_clk;
   // Divide-by-two prescaler
   always @(posedge timer_clk) timer_prescaled_clk <= ~timer_prescaled_clk;
   always @(posedge timer_clk) if (timer_gate_out) count_r <= count_r + 8'h01;
endmodule : dcc_far_model

// File: tb/tb_dcc_top.sv
// Self-checking bench for the comparator control block.
`timescale 1ns/1ns
module tb_dcc_top;
   localparam logic [7:0] GIC = dcc_pkg::IDX_GLOBAL_IRQ;
   localparam logic [7:0] FLG = dcc_pkg::IDX_PERIPH_FLAG;
   localparam logic [7:0] CFG = dcc_pkg::IDX_CMP_CONFIG;
   localparam logic [7:0] LNK = dcc_pkg::IDX_TIMER_LINK;
   localparam logic [7:0] ENA = dcc_pkg::IDX_PERIPH_EN;
   localparam logic [7:0] REF = dcc_pkg::IDX_REF_CONTROL;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, gpin = 1'b0, pact = 1'b0, sleep = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [1:0]  dir = 2'h0;
   logic [7:0]  pos1 = 8'h00, pos2 = 8'h00, v, exp_q[$];
   logic [6:0]  lvl;
   logic        pready, r1, r2, tck, tpck, gate, irq, wake, p1, o1, p2, o2;
   logic [7:0]  idx_t[6] = '{GIC, FLG, CFG, LNK, ENA, REF};
   logic [7:0]  rst_t[6] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
   integer      seed = 92453, fail_count = 0, total_checks = 0, cyc = 0;
   dcc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(), .first_raw(r1),
      .second_raw(r2), .timer_gate_pin(gpin), .timer_clk(tck),
      .timer_prescaled_clk(tpck), .timer_prescale_active(pact),
      .timer_gate_out(gate), .pin_direction_bits(dir), .first_pin_out(p1),
      .first_pin_oe(o1), .second_pin_out(p2), .second_pin_oe(o2),
      .operating_mode_sel(), .input_switch(), .comparators_powered(),
      .reference_power_on(), .reference_range_sel(),
      .reference_level_code(), .internal_reference_level(lvl),
      .sleep_active(sleep), .change_irq(irq), .wake_request(wake));
   dcc_far_model u_far (.first_pos(pos1), .second_pos(pos2),
      .timer_gate_out(gate), .first_raw(r1), .second_raw(r2),
      .timer_clk(tck), .timer_prescaled_clk(tpck));
   always #20 pclk = ~pclk;
   // Hang guard: far above the few hundred cycles the run needs
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count = fail_count + 1;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (fail_count == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      total_checks = total_checks + 1;
      if (g !== e) begin
         $display("ERROR %0t got %h expected %h", $time, g, e);
         fail_count = fail_count + 1;
      end
   endtask : chk
   // One APB transfer; held until pready is seen high
   task automatic apb(input logic [7:0] i, input logic w,
                      input logic [7:0] d);
      @(posedge pclk);
      {psel, penable, pwrite} <= {2'b10, w};
      paddr  <= {2'b00, i, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic rd(input logic [7:0] i, input logic [7:0] e);
      exp_q.push_back(e);
      apb(i, 1'b0, 8'h00);
   endtask : rd
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      apb(i, 1'b1, d);
   endtask : wr
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask : wt
   // Reset, then every register must read its default
   task automatic rst_chk();
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(idx_t[i], rst_t[i]);
   endtask : rst_chk
   // Read monitor: oldest note against the returned byte
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
         chk(prdata[7:0], exp_q.pop_front());
   initial begin
      rst_chk();
      rd(8'h00, 8'h00);
      for (int m = 0; m < 8; m++) begin // interrupts off while switching
         wr(CFG, m[7:0]);
         rd(CFG, m[7:0]);
      end
      wr(CFG, 8'hFF);
      rd(CFG, 8'h3F);
      wr(CFG, 8'h06);
      pos1 <= 8'hC0;
      wt(6);
      chk({4'h0, p2, o2, p1, o1}, 8'h07);
      rd(FLG, 8'h08);
      wr(FLG, 8'h00);
      rd(FLG, 8'h08);
      rd(CFG, 8'h46);
      wr(FLG, 8'h00);
      rd(FLG, 8'h00);
      dir <= 2'h1;
      wt(2);
      chk({4'h0, p2, o2, p1, o1}, 8'h06);
      wr(ENA, 8'h08);
      wr(GIC, 8'hC0);
      wr(FLG, 8'h08);
      wt(0);
      chk({6'h0, irq, wake}, 8'h02);
      wr(GIC, 8'h40);
      sleep <= 1'b1;
      wt(1);
      chk({6'h0, irq, wake}, 8'h01);
      rd(CFG, 8'h46);
      sleep <= 1'b0;
      wr(CFG, 8'h16);
      wt(5);
      rd(CFG, 8'h16);
      repeat (8) begin
         v = 8'($random(seed));
         wr(REF, v);
         rd(REF, v & 8'hAF);
         wt(0);
         chk({1'b0, lvl}, !v[7] ? 8'h00 : v[5] ? v[3:0] * 8'h04
                          : 8'h18 + v[3:0] * 8'h03);
      end
      wr(LNK, 8'h00);
      pos2 <= 8'hC0;
      wt(6);
      chk({7'h0, gate}, 8'h01);
      wr(LNK, 8'h01); // sync while gating
      pact <= 1'b1;
      pos2 <= 8'h00;
      wt(40);
      chk({7'h0, gate}, 8'h00);
      @(posedge pclk) pos2 <= 8'hC0;
      wt(40);
      chk({7'h0, gate}, 8'h01);
      wr(LNK, 8'h02);
      gpin <= 1'b1;
      pos2 <= 8'h00;
      wt(6);
      chk({7'h0, gate}, 8'h01);
      chk({7'h0, u_far.count_r != 8'h00}, 8'h01);
      wr(CFG, 8'h07); // comparators off
      wr(REF, 8'h00); // reference off
      sleep <= 1'b1;
      wt(2);
      chk({7'h0, wake}, 8'h00);
      @(posedge pclk);
      rst_chk();
      report_and_stop();
   end
endmodule : tb_dcc_top
bind dcc_top dcc_checker u_chk (.pclk(pclk), .presetn(presetn),
   .operating_mode_sel(operating_mode_sel), .sleep_active(sleep_active),
   .comparators_powered(comparators_powered), .first_pin_oe(first_pin_oe),
   .reference_power_on(reference_power_on), .wake_request(wake_request),
   .reference_range_sel(reference_range_sel), .first_pin_out(first_pin_out),
   .reference_level_code(reference_level_code),
   .second_pin_out(second_pin_out),
   .internal_reference_level(internal_reference_level),
   .pin_direction_bits(pin_direction_bits));
